/* File: rtl/ptr_regs_pkg.sv */
`default_nettype none
package ptr_regs_pkg;
    // register window: offsets from the memory base of either function
    localparam logic [7:0] CFG_BASE_OFFSET = 8'h10;
    localparam logic [7:0] OFF_BULK_CUR = 8'h2C;
    localparam logic [7:0] OFF_DONE_HEAD = 8'h30;
    // field layout of both pointer registers
    localparam int PTR_LSB = 4;
    localparam int PTR_W = 28;
    localparam logic [27:0] PTR_RESET = 28'h0000000;
    localparam logic [3:0] LOW_RESERVED = 4'h0;
    // bit positions in neighbouring registers
    localparam int CTRL_BULK_EN_BIT = 5;
    localparam int CMD_LIST_FILLED_BIT = 1;
    // bus read latency in cycles
    localparam int RD_LATENCY = 1;
endpackage
`default_nettype wire

/* File: rtl/ptr_reg.sv */
`timescale 1ns/100ps
`default_nettype none
// one 28-bit pointer register with priority load and software write
module ptr_reg #(
    parameter int W = 28
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hw_load,
    input wire logic [W-1:0] hw_value,
    input wire logic sw_load,
    input wire logic [W-1:0] sw_value,
    output logic [W-1:0] value
);
    logic [W-1:0] val_ff;
    logic [W-1:0] nxt_val;

    // hardware update wins over a colliding software write
    always_comb begin
        nxt_val = val_ff;
        if (hw_load) begin
            nxt_val = hw_value;
        end else if (sw_load) begin
            nxt_val = sw_value;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            val_ff <= '0;
        end else begin
            val_ff <= nxt_val;
        end
    end

    assign value = val_ff;
endmodule
`default_nettype wire

/* File: rtl/bulk_done_ptrs.sv */
`timescale 1ns/100ps
`default_nettype none
module bulk_done_ptrs (
    input wire logic CLK_SYS,
    input wire logic NRST,
    // register port, same clock domain
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_RVALID,
    // neighbouring register bits
    input wire logic BULK_LIST_ENABLE,
    input wire logic LIST_FILLED_FLAG,
    output logic LIST_FILLED_CLEAR,
    input wire logic [27:0] BULK_LIST_HEAD,
    // list walker
    input wire logic ED_DONE,
    input wire logic [27:0] ED_NEXT_LINK,
    output logic [27:0] BULK_CURRENT_POINTER,
    output logic BULK_AT_END,
    // completion and flush
    input wire logic TD_COMPLETE,
    input wire logic [27:0] TD_ADDR,
    output logic LINK_WR,
    output logic [31:0] LINK_ADDR,
    output logic [31:0] LINK_DATA,
    input wire logic FLUSH_REQ,
    output logic FLUSH_WR,
    output logic [31:0] FLUSH_DATA
);
    // ************************************************************
    // register decode
    // ************************************************************
    logic wr_cur;
    logic wr_done;
    logic [27:0] cur_val;
    logic [27:0] done_val;

    // current pointer write ignored while enabled; walker owns the pointer
    always_comb begin
        wr_cur = 1'b0;
        wr_done = 1'b0;
        if (REG_WR && REG_ADDR == ptr_regs_pkg::OFF_BULK_CUR) begin
            wr_cur = !BULK_LIST_ENABLE;
        end else if (REG_WR && REG_ADDR == ptr_regs_pkg::OFF_DONE_HEAD) begin
            wr_done = 1'b1;
        end
    end

    // ************************************************************
    // bulk current pointer
    // ************************************************************
    logic cur_load;
    logic [27:0] cur_next;
    logic at_end;

    assign at_end = (cur_val == ptr_regs_pkg::PTR_RESET);

    // follow the link in insertion order; at end reload if filled
    always_comb begin
        cur_load = 1'b0;
        cur_next = cur_val;
        LIST_FILLED_CLEAR = 1'b0;
        if (ED_DONE && !at_end) begin
            cur_load = 1'b1;
            cur_next = ED_NEXT_LINK;
        end else if (at_end && BULK_LIST_ENABLE && LIST_FILLED_FLAG) begin
            cur_load = 1'b1;
            cur_next = BULK_LIST_HEAD;
            LIST_FILLED_CLEAR = 1'b1;
        end // flag clear leaves everything alone
    end

    ptr_reg #(.W(ptr_regs_pkg::PTR_W)) u_cur (
        .clk(CLK_SYS),
        .nrst(NRST),
        .hw_load(cur_load),
        .hw_value(cur_next),
        .sw_load(wr_cur),
        .sw_value(REG_WDATA[31:4]),
        .value(cur_val)
    );

    // pointer is never rewound at frame start, only moved above
    assign BULK_CURRENT_POINTER = cur_val;
    assign BULK_AT_END = at_end;

    // ************************************************************
    // done queue head
    // ************************************************************
    logic done_load;
    logic [27:0] done_next;
    logic link_wr_ff;
    logic nxt_link_wr;
    logic [31:0] link_addr_ff;
    logic [31:0] nxt_link_addr;
    logic [31:0] link_data_ff;
    logic [31:0] nxt_link_data;
    logic flush_wr_ff;
    logic nxt_flush_wr;
    logic [31:0] flush_data_ff;
    logic [31:0] nxt_flush_data;

    // a completion in the flush cycle wins and the flush is dropped;
    // the completion links to the unflushed head as usual, so nothing is lost
    always_comb begin
        done_load = 1'b0;
        done_next = done_val;
        nxt_link_wr = 1'b0;
        nxt_link_addr = link_addr_ff;
        nxt_link_data = link_data_ff;
        nxt_flush_wr = 1'b0;
        nxt_flush_data = flush_data_ff;
        if (FLUSH_REQ && !TD_COMPLETE) begin
            nxt_flush_wr = 1'b1;
            nxt_flush_data = {done_val, ptr_regs_pkg::LOW_RESERVED};
            done_load = 1'b1;
            done_next = ptr_regs_pkg::PTR_RESET;
        end else if (TD_COMPLETE) begin
            nxt_link_wr = 1'b1;
            nxt_link_addr = {TD_ADDR, ptr_regs_pkg::LOW_RESERVED};
            nxt_link_data = {done_val, ptr_regs_pkg::LOW_RESERVED};
            done_load = 1'b1;
            done_next = TD_ADDR;
        end
    end

    ptr_reg #(.W(ptr_regs_pkg::PTR_W)) u_done (
        .clk(CLK_SYS),
        .nrst(NRST),
        .hw_load(done_load),
        .hw_value(done_next),
        .sw_load(wr_done),
        .sw_value(REG_WDATA[31:4]),
        .value(done_val)
    );

    // ************************************************************
    // read path and strobes
    // ************************************************************
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;

    // unmapped offsets read zero; low bits always zero
    always_comb begin
        nxt_rvalid = REG_RD;
        nxt_rdata = rdata_ff;
        if (REG_RD && REG_ADDR == ptr_regs_pkg::OFF_BULK_CUR) begin
            nxt_rdata = {cur_val, ptr_regs_pkg::LOW_RESERVED};
        end else if (REG_RD && REG_ADDR == ptr_regs_pkg::OFF_DONE_HEAD) begin
            nxt_rdata = {done_val, ptr_regs_pkg::LOW_RESERVED};
        end else if (REG_RD) begin
            nxt_rdata = 32'h00000000;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            rdata_ff <= 32'h00000000;
            rvalid_ff <= 1'b0;
            link_wr_ff <= 1'b0;
            link_addr_ff <= 32'h00000000;
            link_data_ff <= 32'h00000000;
            flush_wr_ff <= 1'b0;
            flush_data_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            link_wr_ff <= nxt_link_wr;
            link_addr_ff <= nxt_link_addr;
            link_data_ff <= nxt_link_data;
            flush_wr_ff <= nxt_flush_wr;
            flush_data_ff <= nxt_flush_data;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign REG_RVALID = rvalid_ff;
    assign LINK_WR = link_wr_ff;
    assign LINK_ADDR = link_addr_ff;
    assign LINK_DATA = link_data_ff;
    assign FLUSH_WR = flush_wr_ff;
    assign FLUSH_DATA = flush_data_ff;

    // ************************************************************
    // checks
    // ************************************************************
    chk_cur_advance: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        ED_DONE && !at_end |=> cur_val == $past(ED_NEXT_LINK))
        else $error("current pointer did not advance");
    chk_reload_head: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        at_end && BULK_LIST_ENABLE && LIST_FILLED_FLAG
        |-> LIST_FILLED_CLEAR ##1 cur_val == $past(BULK_LIST_HEAD))
        else $error("head not reloaded");
    chk_idle_end: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        at_end && !LIST_FILLED_FLAG && !REG_WR |-> !LIST_FILLED_CLEAR
        ##1 at_end)
        else $error("end of list acted without flag");
    chk_wr_blocked: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        BULK_LIST_ENABLE && !ED_DONE && !LIST_FILLED_FLAG
        |=> $stable(cur_val))
        else $error("current pointer changed while enabled");
    chk_link_data: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        TD_COMPLETE |=> LINK_WR && LINK_DATA[31:4] == $past(done_val)
        && LINK_ADDR[31:4] == $past(TD_ADDR))
        else $error("wrong link value");
    chk_done_head: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        TD_COMPLETE |=> done_val == $past(TD_ADDR))
        else $error("done head not replaced");
    chk_flush_zero: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        FLUSH_REQ && !TD_COMPLETE |=> FLUSH_WR
        && done_val == ptr_regs_pkg::PTR_RESET
        && FLUSH_DATA[31:4] == $past(done_val))
        else $error("flush did not zero head");
    chk_read_low: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        REG_RD |=> REG_RVALID && REG_RDATA[3:0] == 4'h0)
        else $error("low bits not zero");
    chk_read_live: assert property (
        @(posedge CLK_SYS) disable iff (!NRST)
        REG_RD && REG_ADDR == ptr_regs_pkg::OFF_BULK_CUR
        |=> REG_RDATA[31:4] == $past(cur_val))
        else $error("read not live");
    cov_reload: cover property (@(posedge CLK_SYS) LIST_FILLED_CLEAR);
    cov_two_done: cover property (@(posedge CLK_SYS)
        TD_COMPLETE ##1 TD_COMPLETE);
    cov_flush: cover property (@(posedge CLK_SYS)
        FLUSH_WR && FLUSH_DATA != 32'h00000000);
endmodule
`default_nettype wire

/* File: bench/host_mem.sv */
`timescale 1ns/100ps
`default_nettype none
// host side: descriptor memory and shared area
module host_mem (
    input wire logic CLK_SYS,
    input wire logic [27:0] BULK_CURRENT_POINTER,
    output logic [27:0] ED_NEXT_LINK,
    input wire logic LINK_WR,
    input wire logic [31:0] LINK_DATA,
    input wire logic FLUSH_WR,
    input wire logic [31:0] FLUSH_DATA
);
    logic [31:0] link_word;
    logic [31:0] shared_word;
    // list in insertion order, last link zero
    always_comb begin
        case (BULK_CURRENT_POINTER)
            28'h0000010: ED_NEXT_LINK = 28'h0000020;
            28'h0000020: ED_NEXT_LINK = 28'h0000030;
            28'h0000030: ED_NEXT_LINK = 28'h0000000;
            // junk off the list, so a stale link never looks right
            default: ED_NEXT_LINK = ~BULK_CURRENT_POINTER;
        endcase
    end
    // memory writes land here
    always @(posedge CLK_SYS) begin
        if (LINK_WR)
            link_word <= LINK_DATA;
        if (FLUSH_WR)
            shared_word <= FLUSH_DATA;
    end
endmodule
`default_nettype wire

/* File: bench/bulk_done_ptrs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module bulk_done_ptrs_tb;
    typedef struct {logic [27:0] a; logic [27:0] old;} row_t;
    // completions: address in, previous head expected as link
    row_t rows [3] = '{'{28'h1, 28'h0}, '{28'h2, 28'h1}, '{28'h3, 28'h2}};
    logic clk, nrst, wr, rd, rvalid, bulk_list_enable, lff, lfc, ed_done, at_end;
    logic tdc, lwr, freq, fwr;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, ldata, laddr, fdata, e;
    logic [27:0] head, nlink, cur, tda;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    bulk_done_ptrs bulk_done_ptrs_inst (.CLK_SYS(clk), .NRST(nrst),
        .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .BULK_LIST_ENABLE(bulk_list_enable),
        .LIST_FILLED_FLAG(lff), .LIST_FILLED_CLEAR(lfc),
        .BULK_LIST_HEAD(head), .ED_DONE(ed_done), .ED_NEXT_LINK(nlink),
        .BULK_CURRENT_POINTER(cur), .BULK_AT_END(at_end),
        .TD_COMPLETE(tdc), .TD_ADDR(tda), .LINK_WR(lwr), .LINK_ADDR(laddr),
        .LINK_DATA(ldata), .FLUSH_REQ(freq), .FLUSH_WR(fwr),
        .FLUSH_DATA(fdata));
    host_mem host_mem_inst (.CLK_SYS(clk), .BULK_CURRENT_POINTER(cur),
        .ED_NEXT_LINK(nlink), .LINK_WR(lwr), .LINK_DATA(ldata),
        .FLUSH_WR(fwr), .FLUSH_DATA(fdata));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // strobes last one cycle, then one idle edge, so back-to-back
    // calls never flip a strobe twice in one time step
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] exp);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk({31'h0, rvalid}, 32'h1);
        chk(rdata, exp);
        @(negedge clk);
    endtask
    task conclude;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // hang guard, far above the ~60 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        bulk_list_enable = 1'b0;
        lff = 1'b0;
        head = 28'h10;
        ed_done = 1'b0;
        tdc = 1'b0;
        tda = 28'h0;
        freq = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        chk({31'h0, at_end}, 32'h1);
        rd_reg(8'h2C, 32'h0);
        rd_reg(8'h30, 32'h0);
        rd_reg(8'h34, 32'h0);
        $display("reset test done");
        // completions chain onto the done queue
        for (int i = 0; i < 3; i++) begin
            tda = rows[i].a;
            tdc = 1'b1;
            @(negedge clk);
            tdc = 1'b0;
            chk({31'h0, lwr}, 32'h1);
            chk(ldata, {rows[i].old, 4'h0});
            chk(laddr, {rows[i].a, 4'h0});
            @(negedge clk);
        end
        chk(host_mem_inst.link_word, 32'h20);
        rd_reg(8'h30, 32'h30);
        freq = 1'b1;
        @(negedge clk);
        freq = 1'b0;
        chk({31'h0, fwr}, 32'h1);
        chk(fdata, 32'h30);
        @(negedge clk);
        chk(host_mem_inst.shared_word, 32'h30);
        rd_reg(8'h30, 32'h0);
        wr_reg(8'h30, 32'h12345670);
        rd_reg(8'h30, 32'h12345670);
        // unmapped write must touch neither pointer
        wr_reg(8'h34, 32'hFFFFFFF0);
        rd_reg(8'h30, 32'h12345670);
        rd_reg(8'h2C, 32'h0);
        // flush colliding with a completion: completion kept, flush dropped
        tda = 28'h4;
        tdc = 1'b1;
        freq = 1'b1;
        @(negedge clk);
        tdc = 1'b0;
        freq = 1'b0;
        chk({31'h0, fwr}, 32'h0);
        chk({31'h0, lwr}, 32'h1);
        chk(ldata, 32'h12345670);
        chk(laddr, 32'h40);
        @(negedge clk);
        rd_reg(8'h30, 32'h40);
        $display("done queue test done");
        // software load while disabled, then refused while enabled
        wr_reg(8'h2C, 32'h100);
        rd_reg(8'h2C, 32'h100);
        bulk_list_enable = 1'b1;
        wr_reg(8'h2C, 32'h500);
        rd_reg(8'h2C, 32'h100);
        for (int i = 1; i <= 3; i++) begin
            ed_done = 1'b1;
            @(negedge clk);
            ed_done = 1'b0;
            e = (i == 3) ? 32'h0 : 32'h10 * (i + 1);
            chk({4'h0, cur}, e);
            rd_reg(8'h2C, e << 4);
        end
        // end of list with the flag clear: nothing moves
        repeat (3) @(negedge clk);
        chk({4'h0, cur}, 32'h0);
        chk({31'h0, at_end}, 32'h1);
        chk({31'h0, lfc}, 32'h0);
        lff = 1'b1;
        #1;
        chk({31'h0, lfc}, 32'h1);
        @(negedge clk);
        lff = 1'b0;
        chk({4'h0, cur}, 32'h10);
        $display("bulk walk test done");
        // reset in mid-run: pointer back to zero, end of list again
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        chk({4'h0, cur}, 32'h0);
        chk({31'h0, at_end}, 32'h1);
        rd_reg(8'h2C, 32'h0);
        $display("mid-run reset test done");
        conclude();
    end
endmodule
`default_nettype wire
